// file: hw/lbr_pkg.sv
// package: offsets, fields, reset values and timing for the link topology and maintenance registers
package lbr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] TOPO_INFO_OFS = 12'h058;
  localparam logic [11:0] MAINT_OFS = 12'h05c;
  // topology_info_reg fields
  localparam int unsigned TOPO_OK_BIT = 31;
  localparam int unsigned NODES_LSB = 24;
  localparam int unsigned ROOT_BIT = 23;
  localparam int unsigned MGR_PIN_BIT = 22;
  localparam int unsigned RM_ID_LSB = 16;
  localparam int unsigned BUS_ID_LSB = 6;
  localparam int unsigned NODE_IDX_LSB = 0;
  localparam logic [5:0] NODES_RST = 6'h00;
  localparam logic [5:0] RM_ID_RST = 6'h3f;
  localparam logic [9:0] BUS_ID_RST = 10'h3ff;
  localparam logic [5:0] NODE_IDX_RST = 6'h3f;
  // maintenance_reg fields
  localparam int unsigned HDR_CRC_BIT = 31;
  localparam int unsigned PAY_CRC_BIT = 30;
  localparam int unsigned DROP_BIT = 29;
  localparam int unsigned ACK_OVR_BIT = 28;
  localparam int unsigned ACK_SUP_BIT = 27;
  localparam int unsigned ACK_VAL_LSB = 16;
  localparam int unsigned PING_LSB = 0;
  localparam logic [7:0] ACK_VAL_RST = 8'h00;
  localparam logic [7:0] PING_RST = 8'h00;
  localparam logic [7:0] PING_MAX = 8'hff;
  // timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned PING_UNIT_NS = 40;
  localparam int unsigned PING_UNIT_CYC = (PING_UNIT_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [2:0] PING_TICK_LAST = 3'(PING_UNIT_CYC - 1);
  typedef enum logic [1:0] {
    LBR_PING_IDLE = 2'b00,
    LBR_PING_RUN = 2'b01
  } lbr_ping_state_t;
endpackage

// file: hw/lbr_regs.sv
// module: topology information and link maintenance register bank
//
// Function
// - topology_info_ok bit 31 reads 1 only while topology fields hold valid values
// - nodes_seen_count in bits 29:24 is hardware updated and resets to zero
// - bit 23 shows root status; software writes to it do nothing
// - bit 22 mirrors the manager_candidate_pin level at all times
// - resource_manager_id in bits 21:16 reads 0x3f after reset or with no manager
// - local_bus_id resets to 0x3ff, reloaded on bus reset when bus_id_reload_flag set
// - local_node_index set to 0x3f at reset and on each bus reset status with no capture in the same cycle
// - corrupt_header_check corrupts next packet header crc, cleared after it transmits
// - corrupt_payload_check corrupts next payload crc, cleared after packet transmits
// - drop_next_packet discards next primary packet, then hardware clears it
// - override_acknowledge sends bits 23:16 as next ack, cleared after next packet
// - suppress_acknowledge blocks ack transmission, cleared after next packet
// - ping_response_time in bits 7:0 counts ping answer time in 40 ns units
// - reserved bits ignore writes and read zero
`timescale 1ns/1ps
`default_nettype none
module lbr_regs
  import lbr_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic manager_candidate_pin_in,
  input wire logic bus_id_reload_flag_in,
  input wire logic bus_reset_status_in,
  input wire logic topo_capture_in,
  input wire logic [5:0] topo_nodes_in,
  input wire logic topo_root_in,
  input wire logic topo_rm_valid_in,
  input wire logic [5:0] topo_rm_id_in,
  input wire logic [5:0] topo_node_idx_in,
  input wire logic [9:0] topo_bus_id_in,
  input wire logic tx_pkt_done_in,
  input wire logic ping_sent_in,
  input wire logic ping_answer_in,
  output logic corrupt_header_check_out,
  output logic corrupt_payload_check_out,
  output logic drop_next_packet_out,
  output logic override_acknowledge_out,
  output logic [7:0] ack_value_out,
  output logic suppress_acknowledge_out
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr_topo;
  logic wr_maint;
  assign wr_topo = reg_wr_in && hit(reg_addr_in, TOPO_INFO_OFS);
  assign wr_maint = reg_wr_in && hit(reg_addr_in, MAINT_OFS);

  // ----------------------------------------
  // topology state
  // ----------------------------------------
  logic topo_ok_q;
  logic [5:0] nodes_q;
  logic root_q;
  logic [5:0] rm_id_q;
  logic [9:0] bus_id_q;
  logic [5:0] node_idx_q;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      topo_ok_q <= 1'b0;
    end else if (topo_capture_in) begin
      topo_ok_q <= 1'b1;
    end else if (bus_reset_status_in) begin
      topo_ok_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      nodes_q <= NODES_RST;
      root_q <= 1'b0;
      rm_id_q <= RM_ID_RST;
    end else if (topo_capture_in) begin
      nodes_q <= topo_nodes_in;
      root_q <= topo_root_in;
      rm_id_q <= topo_rm_valid_in ? topo_rm_id_in : RM_ID_RST;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      node_idx_q <= NODE_IDX_RST;
    end else if (topo_capture_in) begin
      node_idx_q <= topo_node_idx_in;
    end else if (bus_reset_status_in) begin
      node_idx_q <= NODE_IDX_RST;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_id_q <= BUS_ID_RST;
    end else if (topo_capture_in) begin
      bus_id_q <= topo_bus_id_in;
    end else if (bus_reset_status_in && bus_id_reload_flag_in) begin
      bus_id_q <= BUS_ID_RST;
    end
  end

  // ----------------------------------------
  // maintenance flags: a write that sets wins over the packet-done clear
  // ----------------------------------------
  logic hdr_q;
  logic pay_q;
  logic drop_q;
  logic ovr_q;
  logic sup_q;
  logic [7:0] ack_val_q;

  function automatic logic flag_next(input logic cur, input logic wr, input logic wbit, input logic done);
    if (wr) begin
      flag_next = wbit;
    end else if (done) begin
      flag_next = 1'b0;
    end else begin
      flag_next = cur;
    end
  endfunction

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hdr_q <= 1'b0;
      pay_q <= 1'b0;
      drop_q <= 1'b0;
      ovr_q <= 1'b0;
      sup_q <= 1'b0;
    end else begin
      hdr_q <= flag_next(hdr_q, wr_maint, reg_wdata_in[HDR_CRC_BIT], tx_pkt_done_in);
      pay_q <= flag_next(pay_q, wr_maint, reg_wdata_in[PAY_CRC_BIT], tx_pkt_done_in);
      drop_q <= flag_next(drop_q, wr_maint, reg_wdata_in[DROP_BIT], tx_pkt_done_in);
      ovr_q <= flag_next(ovr_q, wr_maint, reg_wdata_in[ACK_OVR_BIT], tx_pkt_done_in);
      sup_q <= flag_next(sup_q, wr_maint, reg_wdata_in[ACK_SUP_BIT], tx_pkt_done_in);
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_val_q <= ACK_VAL_RST;
    end else if (wr_maint) begin
      ack_val_q <= reg_wdata_in[ACK_VAL_LSB +: 8];
    end
  end

  assign corrupt_header_check_out = hdr_q;
  assign corrupt_payload_check_out = pay_q;
  assign drop_next_packet_out = drop_q;
  assign override_acknowledge_out = ovr_q;
  assign ack_value_out = ack_val_q;
  assign suppress_acknowledge_out = sup_q;

  // ----------------------------------------
  // ping timer in 40 ns units
  // ----------------------------------------
  lbr_ping_state_t ping_st_q;
  logic [2:0] tick_q;
  logic [7:0] run_cnt_q;
  logic [7:0] ping_q;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ping_st_q <= LBR_PING_IDLE;
    end else begin
      unique case (ping_st_q)
        LBR_PING_IDLE: begin
          if (ping_sent_in) begin
            ping_st_q <= LBR_PING_RUN;
          end
        end
        LBR_PING_RUN: begin
          if (ping_answer_in) begin
            ping_st_q <= LBR_PING_IDLE;
          end
        end
        default: begin
          ping_st_q <= LBR_PING_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_q <= 3'h0;
      run_cnt_q <= PING_RST;
    end else if (ping_st_q == LBR_PING_IDLE) begin
      tick_q <= 3'h0;
      run_cnt_q <= PING_RST;
    end else if (tick_q == PING_TICK_LAST) begin
      tick_q <= 3'h0;
      if (run_cnt_q != PING_MAX) begin
        run_cnt_q <= run_cnt_q + 8'h01;
      end
    end else begin
      tick_q <= tick_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ping_q <= PING_RST;
    end else if (ping_st_q == LBR_PING_RUN && ping_answer_in) begin
      ping_q <= run_cnt_q;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [31:0] topo_word;
  logic [31:0] maint_word;

  always_comb begin
    topo_word = 32'h0000_0000;
    topo_word[TOPO_OK_BIT] = topo_ok_q;
    topo_word[NODES_LSB +: 6] = nodes_q;
    topo_word[ROOT_BIT] = root_q;
    topo_word[MGR_PIN_BIT] = manager_candidate_pin_in;
    topo_word[RM_ID_LSB +: 6] = rm_id_q;
    topo_word[BUS_ID_LSB +: 10] = bus_id_q;
    topo_word[NODE_IDX_LSB +: 6] = node_idx_q;
  end

  always_comb begin
    maint_word = 32'h0000_0000;
    maint_word[HDR_CRC_BIT] = hdr_q;
    maint_word[PAY_CRC_BIT] = pay_q;
    maint_word[DROP_BIT] = drop_q;
    maint_word[ACK_OVR_BIT] = ovr_q;
    maint_word[ACK_SUP_BIT] = sup_q;
    maint_word[ACK_VAL_LSB +: 8] = ack_val_q;
    maint_word[PING_LSB +: 8] = ping_q;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in && hit(reg_addr_in, TOPO_INFO_OFS)) begin
      reg_rdata_out <= topo_word;
    end else if (reg_rd_in && hit(reg_addr_in, MAINT_OFS)) begin
      reg_rdata_out <= maint_word;
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_reset_status;
    bus_reset_status_in && !topo_capture_in;
  endsequence

  sequence s_ping_window;
    ping_st_q == LBR_PING_IDLE && ping_sent_in ##1 !ping_answer_in [*8];
  endsequence

  property p_ok_clear;
    @(posedge core_clk_in) disable iff (rst_in)
    s_reset_status |=> !topo_ok_q && node_idx_q == NODE_IDX_RST;
  endproperty
  a_ok_clear: assert property (p_ok_clear) else $error("valid or node index not reset by bus reset");

  property p_ok_set;
    @(posedge core_clk_in) disable iff (rst_in)
    topo_capture_in |=> topo_ok_q && nodes_q == $past(topo_nodes_in) && node_idx_q == $past(topo_node_idx_in);
  endproperty
  a_ok_set: assert property (p_ok_set) else $error("capture did not load topology");

  property p_root_ro;
    @(posedge core_clk_in) disable iff (rst_in)
    wr_topo && !topo_capture_in |=> $stable(root_q) && $stable(nodes_q);
  endproperty
  a_root_ro: assert property (p_root_ro) else $error("software write changed root or node count");

  property p_pin_mirror;
    @(posedge core_clk_in) disable iff (rst_in)
    reg_rd_in && hit(reg_addr_in, TOPO_INFO_OFS) |=> reg_rdata_out[MGR_PIN_BIT] == $past(manager_candidate_pin_in);
  endproperty
  a_pin_mirror: assert property (p_pin_mirror) else $error("manager pin not mirrored");

  property p_rm_none;
    @(posedge core_clk_in) disable iff (rst_in)
    topo_capture_in && !topo_rm_valid_in |=> rm_id_q == RM_ID_RST;
  endproperty
  a_rm_none: assert property (p_rm_none) else $error("manager id not 3f without manager");

  property p_bus_reload;
    @(posedge core_clk_in) disable iff (rst_in)
    s_reset_status ##0 bus_id_reload_flag_in |=> bus_id_q == BUS_ID_RST;
  endproperty
  a_bus_reload: assert property (p_bus_reload) else $error("bus id not reloaded");

  property p_bus_keep;
    @(posedge core_clk_in) disable iff (rst_in)
    s_reset_status ##0 !bus_id_reload_flag_in |=> $stable(bus_id_q);
  endproperty
  a_bus_keep: assert property (p_bus_keep) else $error("bus id reloaded without flag");

  property p_flags_clear;
    @(posedge core_clk_in) disable iff (rst_in)
    tx_pkt_done_in && !wr_maint |=> !hdr_q && !pay_q && !drop_q && !ovr_q && !sup_q;
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("maintenance flag survived packet");

  property p_set_wins;
    @(posedge core_clk_in) disable iff (rst_in)
    wr_maint && reg_wdata_in[DROP_BIT] |=> drop_next_packet_out;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("drop request lost");

  property p_ack_value;
    @(posedge core_clk_in) disable iff (rst_in)
    wr_maint |=> ack_value_out == $past(reg_wdata_in[ACK_VAL_LSB +: 8]) && override_acknowledge_out == $past(reg_wdata_in[ACK_OVR_BIT]);
  endproperty
  a_ack_value: assert property (p_ack_value) else $error("ack override value wrong");

  property p_sup_hold;
    @(posedge core_clk_in) disable iff (rst_in)
    suppress_acknowledge_out && !tx_pkt_done_in && !wr_maint |=> suppress_acknowledge_out;
  endproperty
  a_sup_hold: assert property (p_sup_hold) else $error("suppress cleared without packet");

  property p_ping_unit;
    @(posedge core_clk_in) disable iff (rst_in)
    s_ping_window ##1 ping_answer_in |=> ping_q == 8'h01;
  endproperty
  a_ping_unit: assert property (p_ping_unit) else $error("ping time not one 40 ns unit");

  property p_reserved;
    @(posedge core_clk_in) disable iff (rst_in)
    reg_rd_in && hit(reg_addr_in, MAINT_OFS) |=> reg_rdata_out[26:24] == 3'h0 && reg_rdata_out[15:8] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

endmodule
`default_nettype wire

// file: dv/lbr_phy_model.sv
// partner model: phy-side source of topology, packet and ping events
`timescale 1ns/1ps
`default_nettype none
module lbr_phy_model (
  input wire logic core_clk_in,
  output logic bus_reset_status_out,
  output logic topo_capture_out,
  output logic [29:0] topo_data_out,
  output logic tx_pkt_done_out,
  output logic ping_sent_out,
  output logic ping_answer_out
);
  initial begin
    {bus_reset_status_out, tx_pkt_done_out, ping_sent_out} = 3'h0;
    {topo_capture_out, ping_answer_out} = 2'h0;
    topo_data_out = 30'h2aaaaaaa;
  end
  // one-cycle pulse: {bus reset status, packet done, ping sent}
  task automatic pulse(input logic [2:0] sel);
    @(posedge core_clk_in);
    {bus_reset_status_out, tx_pkt_done_out, ping_sent_out} <= sel;
    @(posedge core_clk_in);
    {bus_reset_status_out, tx_pkt_done_out, ping_sent_out} <= 3'h0;
  endtask
  // capture strobe with data; data turns over once no longer qualified
  task automatic capture(input logic [29:0] v);
    @(posedge core_clk_in);
    topo_capture_out <= 1'b1;
    topo_data_out <= v;
    @(posedge core_clk_in);
    topo_capture_out <= 1'b0;
    topo_data_out <= ~v;
  endtask
  // answer sampled k edges after the ping-sent edge
  task automatic ping(input int k);
    pulse(3'h1);
    repeat (k - 1) @(posedge core_clk_in);
    ping_answer_out <= 1'b1;
    @(posedge core_clk_in);
    ping_answer_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/lbr_regs_bench.sv
// testbench: register access, topology events, maintenance flags, ping timer
`timescale 1ns/1ps
`default_nettype none
module lbr_regs_bench
  import lbr_pkg::*;
();
  localparam logic [31:0] M_ALL = 32'hffffffff;
  localparam logic [31:0] M_RST = 32'h8040ffff;
  logic core_clk_in;
  logic rst_in;
  logic [11:0] reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic manager_candidate_pin_in;
  logic bus_id_reload_flag_in;
  logic bus_reset_status_in, topo_capture_in, tx_pkt_done_in, ping_sent_in, ping_answer_in;
  logic [29:0] td;
  logic [31:0] reg_rdata_out;
  logic corrupt_header_check_out, corrupt_payload_check_out, drop_next_packet_out;
  logic override_acknowledge_out, suppress_acknowledge_out;
  logic [7:0] ack_value_out;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;

  lbr_phy_model phy (
    .core_clk_in,
    .bus_reset_status_out(bus_reset_status_in),
    .topo_capture_out(topo_capture_in),
    .topo_data_out(td),
    .tx_pkt_done_out(tx_pkt_done_in),
    .ping_sent_out(ping_sent_in),
    .ping_answer_out(ping_answer_in)
  );
  lbr_regs uut (
    .core_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .manager_candidate_pin_in, .bus_id_reload_flag_in, .bus_reset_status_in, .topo_capture_in,
    .topo_nodes_in(td[29:24]), .topo_root_in(td[23]), .topo_rm_valid_in(td[22]),
    .topo_rm_id_in(td[21:16]), .topo_node_idx_in(td[15:10]), .topo_bus_id_in(td[9:0]),
    .tx_pkt_done_in, .ping_sent_in, .ping_answer_in, .corrupt_header_check_out,
    .corrupt_payload_check_out, .drop_next_packet_out, .override_acknowledge_out,
    .ack_value_out, .suppress_acknowledge_out
  );

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask
  // read, compare under mask, then see the data fall back to zero
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out & m, exp & m);
    @(posedge core_clk_in);
    #1;
    chk(reg_rdata_out, 32'h0);
  endtask
  function automatic logic [31:0] topo(input logic ok, input logic [5:0] n, input logic r,
                                       input logic [5:0] rm, input logic [9:0] b, input logic [5:0] i);
    return {ok, 1'b0, n, r, manager_candidate_pin_in, rm, b, i};
  endfunction
  function automatic logic [31:0] flags();
    return {8'h0, ack_value_out, 11'h0, corrupt_header_check_out, corrupt_payload_check_out,
            drop_next_packet_out, override_acknowledge_out, suppress_acknowledge_out};
  endfunction

  initial begin
    forever begin
      @(posedge core_clk_in);
      cycles++;
      if (cycles >= 6000) begin
        failures++;
        end_of_test();
      end
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_in = 1'b1;
    reg_addr_in = 12'h000;
    reg_wdata_in = 32'h0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    manager_candidate_pin_in = 1'b0;
    bus_id_reload_flag_in = 1'b0;
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rdc(TOPO_INFO_OFS, topo(1'b0, NODES_RST, 1'b0, RM_ID_RST, BUS_ID_RST, NODE_IDX_RST), M_ALL);
    rdc(MAINT_OFS, 32'h0, M_ALL);
    chk(flags(), 32'h0);
    @(posedge core_clk_in);
    manager_candidate_pin_in <= 1'b1;
    wr(TOPO_INFO_OFS, M_ALL);
    rdc(TOPO_INFO_OFS, topo(1'b0, NODES_RST, 1'b0, RM_ID_RST, BUS_ID_RST, NODE_IDX_RST), M_ALL);
    phy.capture({6'h05, 1'b1, 1'b1, 6'h12, 6'h07, 10'h155});
    rdc(TOPO_INFO_OFS, topo(1'b1, 6'h05, 1'b1, 6'h12, 10'h155, 6'h07), M_ALL);
    @(posedge core_clk_in);
    bus_id_reload_flag_in <= 1'b1;
    phy.pulse(3'h4);
    rdc(TOPO_INFO_OFS, topo(1'b0, 6'h00, 1'b0, 6'h00, 10'h3ff, 6'h3f), M_RST);
    phy.capture({6'h3e, 1'b0, 1'b0, 6'h00, 6'h01, 10'h0aa});
    rdc(TOPO_INFO_OFS, topo(1'b1, 6'h3e, 1'b0, 6'h3f, 10'h0aa, 6'h01), M_ALL);
    @(posedge core_clk_in);
    bus_id_reload_flag_in <= 1'b0;
    phy.pulse(3'h4);
    rdc(TOPO_INFO_OFS, topo(1'b0, 6'h00, 1'b0, 6'h00, 10'h0aa, 6'h3f), M_RST);
    wr(MAINT_OFS, M_ALL);
    chk(flags(), 32'h00ff001f);
    rdc(MAINT_OFS, 32'hf8ff0000, M_ALL);
    phy.pulse(3'h2);
    #1;
    chk(flags(), 32'h00ff0000);
    rdc(MAINT_OFS, 32'h00ff0000, M_ALL);
    for (int b = 27; b < 32; b++) begin
      wr(MAINT_OFS, (32'h1 << b) | 32'h00a50000);
      chk(flags(), (32'h1 << (b - 27)) | 32'h00a50000);
    end
    // write and packet-done in one cycle: the written value wins
    fork
      wr(MAINT_OFS, 32'h20000000);
      phy.pulse(3'h2);
    join
    chk(flags(), 32'h00000004);
    wr(MAINT_OFS, 32'h0);
    chk(flags(), 32'h0);
    phy.ping(9);
    rdc(MAINT_OFS, 32'h01, 32'hff);
    phy.ping(25);
    rdc(MAINT_OFS, 32'h03, 32'hff);
    phy.ping(2200);
    rdc(MAINT_OFS, 32'hff, 32'hff);
    wr(12'h060, M_ALL);
    rdc(12'h060, 32'h0, M_ALL);
    rdc(MAINT_OFS, 32'h000000ff, M_ALL);
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    manager_candidate_pin_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rdc(MAINT_OFS, 32'h0, M_ALL);
    rdc(TOPO_INFO_OFS, topo(1'b0, NODES_RST, 1'b0, RM_ID_RST, BUS_ID_RST, NODE_IDX_RST), M_ALL);
    end_of_test();
  end
endmodule
`default_nettype wire
